/* File: inc/otfr_pkg.sv */
// Constants, field layout and types of the overtemperature fault-response sequencer.
// Assumes a single 20 MHz system clock and a plain register write/read port.
//
// Overview of operation
// - Configuration register lives at address 0x50
// - Response bits 7:6; code 00 ignores fault
// - Code 01 keeps running for first delay
// - Code 01: still faulted, disable then retry
// - Code 10 disables at once, then retries
// - Code 11 disables while fault persists
// - Code 11 re-enables once fault clears
// - Bits 5:3 give 0-6 retries, 7 unlimited
// - Retries exhausted: stay off until reset
// - Bits 2:0 pick disable delay, retry spacing
// - Codes 0-2: 10/20/40 ms, 252/558/924 ms
package otfr_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and time base
   localparam int unsigned OTFR_CLK_HZ = 20_000_000;
   localparam int unsigned OTFR_MS_PER_S = 1000;
   localparam int unsigned OTFR_MS_CYCLES = OTFR_CLK_HZ / OTFR_MS_PER_S;
   localparam int unsigned OTFR_PRE_W = 16;
   localparam int unsigned OTFR_MS_W = 12;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [7:0] OTFR_CFG_ADDR = 8'h50;
   localparam logic [7:0] OTFR_CFG_RESET = 8'h00;
   localparam logic [7:0] OTFR_RDATA_NONE = 8'h00;

   // Field positions of the configuration byte
   localparam int unsigned OTFR_RESP_LSB = 6;
   localparam int unsigned OTFR_RETRY_LSB = 3;
   localparam int unsigned OTFR_DELAY_LSB = 0;

   typedef struct packed
   {
      logic [1:0] resp;
      logic [2:0] retry;
      logic [2:0] delay;
   } otfr_cfg_type;

   localparam logic [1:0] OTFR_RESP_IGNORE = 2'h0;
   localparam logic [1:0] OTFR_RESP_DELAYED = 2'h1;
   localparam logic [1:0] OTFR_RESP_IMMED = 2'h2;
   localparam logic [1:0] OTFR_RESP_HOLD = 2'h3;

   localparam logic [2:0] OTFR_RETRY_NONE = 3'h0;
   localparam logic [2:0] OTFR_RETRY_LAST = 3'h1;
   localparam logic [2:0] OTFR_RETRY_UNLIM = 3'h7;

   ////////////////////////////////////////////////////////////////////////////////
   // Delay tables in milliseconds, indexed by the delay code
   localparam logic [7:0][11:0] OTFR_DLY1_MS =
      {12'd1280, 12'd640, 12'd320, 12'd160, 12'd80, 12'd40, 12'd20, 12'd10};
   localparam logic [7:0][11:0] OTFR_DLY2_MS =
      {12'd2604, 12'd2268, 12'd1932, 12'd1596, 12'd1260, 12'd924, 12'd558, 12'd252};

   function automatic logic [11:0] otfr_dly1_ms(input logic [2:0] code);
      return OTFR_DLY1_MS[code];
   endfunction

   function automatic logic [11:0] otfr_dly2_ms(input logic [2:0] code);
      return OTFR_DLY2_MS[code];
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer states
   typedef enum logic [4:0]
   {
      OTFR_ST_RUN = 5'h01,
      OTFR_ST_DLY = 5'h02,
      OTFR_ST_OFF = 5'h04,
      OTFR_ST_HOLD = 5'h08,
      OTFR_ST_LATCH = 5'h10
   } otfr_state_type;

endpackage

/* File: hw/otfr_timer.sv */
// Millisecond delay timer for the fault-response sequencer.
// Assumes start pulses come from logic on the same clock; target is at least 1 ms.
module otfr_timer
   import otfr_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P = OTFR_MS_CYCLES
)
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // Control
   input wire logic start_in,
   input wire logic [OTFR_MS_W-1:0] target_ms_in,
   // Status
   output logic done_out
);

   localparam logic [OTFR_PRE_W-1:0] PRE_LAST = OTFR_PRE_W'(MS_CYCLES_P - 1);

   if (MS_CYCLES_P < 1 || MS_CYCLES_P > 65535)
   begin : g_chk
      $error("otfr_timer: MS_CYCLES_P out of range");
   end

   logic [OTFR_PRE_W-1:0] pre_ff, nxt_pre;
   logic [OTFR_MS_W-1:0] ms_ff, nxt_ms;
   logic [OTFR_MS_W-1:0] tgt_ff, nxt_tgt;
   logic done_ff, nxt_done;
   logic [OTFR_MS_W-1:0] ms_inc;

   always_comb
   begin
      ms_inc = OTFR_MS_W'(ms_ff + 1'b1);
      nxt_pre = pre_ff;
      nxt_ms = ms_ff;
      nxt_tgt = tgt_ff;
      nxt_done = done_ff;
      if (start_in)
      begin
         nxt_pre = '0;
         nxt_ms = '0;
         nxt_tgt = target_ms_in;
         nxt_done = 1'b0;
      end
      else if (!done_ff)
      begin
         if (pre_ff == PRE_LAST)
         begin
            nxt_pre = '0;
            nxt_ms = ms_inc;
            nxt_done = (ms_inc == tgt_ff);
         end
         else
         begin
            nxt_pre = OTFR_PRE_W'(pre_ff + 1'b1);
         end
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pre_ff <= '0;
         ms_ff <= '0;
         tgt_ff <= '0;
         done_ff <= 1'b0;
      end
      else if (ce_in)
      begin
         pre_ff <= nxt_pre;
         ms_ff <= nxt_ms;
         tgt_ff <= nxt_tgt;
         done_ff <= nxt_done;
      end
   end

   assign done_out = done_ff;

endmodule

/* File: hw/otfr_top.sv */
// Overtemperature fault-response sequencer: configuration register and state machine
// that drives the power-stage output enable.
// Assumes the fault pin is asynchronous and the register port is on clk_sys_in.
module otfr_top
   import otfr_pkg::*;
#(
   parameter int unsigned MS_CYCLES_P = OTFR_MS_CYCLES
)
(
   // Clock, reset, enable
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic ce_in,
   // Fault pin
   input wire logic ot_fault_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   // Power stage and status
   output logic out_en_out,
   output logic [4:0] fsm_state_out,
   output logic [2:0] retries_left_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // Fault pin synchroniser and agreement filter

   logic [2:0] sync_ff, nxt_sync;
   logic fault_ff, nxt_fault;

   always_comb
   begin
      nxt_sync = {sync_ff[1:0], ot_fault_in};
      nxt_fault = fault_ff;
      // A level is accepted only once the last two stages agree
      if (sync_ff[1] == sync_ff[2])
      begin
         nxt_fault = sync_ff[2];
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sync_ff <= '0;
         fault_ff <= 1'b0;
      end
      else if (ce_in)
      begin
         sync_ff <= nxt_sync;
         fault_ff <= nxt_fault;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration register

   otfr_cfg_type cfg_ff, nxt_cfg;
   logic [7:0] rdata_ff, nxt_rdata;
   logic cfg_hit;

   always_comb
   begin
      cfg_hit = (reg_addr_in == OTFR_CFG_ADDR);
      nxt_cfg = cfg_ff;
      if (reg_wr_in && cfg_hit)
      begin
         nxt_cfg = otfr_cfg_type'(reg_wdata_in);
      end
      nxt_rdata = cfg_hit ? 8'(cfg_ff) : OTFR_RDATA_NONE;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cfg_ff <= otfr_cfg_type'(OTFR_CFG_RESET);
         rdata_ff <= OTFR_RDATA_NONE;
      end
      else if (ce_in)
      begin
         cfg_ff <= nxt_cfg;
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Response state machine

   otfr_state_type state_ff, nxt_state;
   logic [2:0] retry_ff, nxt_retry;
   logic out_en_ff, nxt_out_en;
   logic tmr_start;
   logic tmr_done;
   logic [OTFR_MS_W-1:0] tmr_target;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_retry = retry_ff;
      tmr_start = 1'b0;
      tmr_target = otfr_dly2_ms(cfg_ff.delay);
      case (state_ff)
         OTFR_ST_RUN:
         begin
            if (fault_ff)
            begin
               case (cfg_ff.resp)
                  OTFR_RESP_DELAYED:
                  begin
                     nxt_state = OTFR_ST_DLY;
                     tmr_start = 1'b1;
                     tmr_target = otfr_dly1_ms(cfg_ff.delay);
                  end
                  OTFR_RESP_IMMED:
                  begin
                     // Zero retries means the first shutdown is final
                     if (cfg_ff.retry == OTFR_RETRY_NONE)
                     begin
                        nxt_state = OTFR_ST_LATCH;
                     end
                     else
                     begin
                        nxt_state = OTFR_ST_OFF;
                        nxt_retry = cfg_ff.retry;
                        tmr_start = 1'b1;
                     end
                  end
                  OTFR_RESP_HOLD:
                  begin
                     nxt_state = OTFR_ST_HOLD;
                  end
                  default:
                  begin
                     nxt_state = OTFR_ST_RUN;
                  end
               endcase
            end
         end
         OTFR_ST_DLY:
         begin
            if (!fault_ff)
            begin
               nxt_state = OTFR_ST_RUN;
            end
            else if (tmr_done)
            begin
               if (cfg_ff.retry == OTFR_RETRY_NONE)
               begin
                  nxt_state = OTFR_ST_LATCH;
               end
               else
               begin
                  nxt_state = OTFR_ST_OFF;
                  nxt_retry = cfg_ff.retry;
                  tmr_start = 1'b1;
               end
            end
         end
         OTFR_ST_OFF:
         begin
            // Each expiry of the spacing is one restart attempt
            if (tmr_done)
            begin
               if (!fault_ff)
               begin
                  nxt_state = OTFR_ST_RUN;
               end
               else if (retry_ff == OTFR_RETRY_UNLIM)
               begin
                  tmr_start = 1'b1;
               end
               else if (retry_ff == OTFR_RETRY_LAST)
               begin
                  nxt_state = OTFR_ST_LATCH;
                  nxt_retry = OTFR_RETRY_NONE;
               end
               else
               begin
                  nxt_retry = 3'(retry_ff - 1'b1);
                  tmr_start = 1'b1;
               end
            end
         end
         OTFR_ST_HOLD:
         begin
            if (!fault_ff)
            begin
               nxt_state = OTFR_ST_RUN;
            end
         end
         OTFR_ST_LATCH:
         begin
            // Only reset leaves this state
            nxt_state = OTFR_ST_LATCH;
         end
         default:
         begin
            nxt_state = OTFR_ST_RUN;
         end
      endcase
      nxt_out_en = (nxt_state == OTFR_ST_RUN) || (nxt_state == OTFR_ST_DLY);
   end

   always_ff @(posedge clk_sys_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_ff <= OTFR_ST_RUN;
         retry_ff <= OTFR_RETRY_NONE;
         out_en_ff <= 1'b1;
      end
      else if (ce_in)
      begin
         state_ff <= nxt_state;
         retry_ff <= nxt_retry;
         out_en_ff <= nxt_out_en;
      end
   end

   otfr_timer #(
      .MS_CYCLES_P(MS_CYCLES_P)
   ) u_timer (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .start_in(tmr_start),
      .target_ms_in(tmr_target),
      .done_out(tmr_done)
   );

   assign reg_rdata_out = rdata_ff;
   assign out_en_out = out_en_ff;
   assign fsm_state_out = state_ff;
   assign retries_left_out = retry_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   sequence fault_seen_s(logic [1:0] code);
      ce_in && state_ff == OTFR_ST_RUN && fault_ff && cfg_ff.resp == code;
   endsequence

   sequence dly_expired_s;
      ce_in && state_ff == OTFR_ST_DLY && fault_ff && tmr_done;
   endsequence

   cfg_write_a: assert property (ce_in && reg_wr_in && cfg_hit |=>
      8'(cfg_ff) == $past(reg_wdata_in))
      else $error("config write not stored");

   ignore_keeps_on_a: assert property (fault_seen_s(OTFR_RESP_IGNORE) |=>
      out_en_out && state_ff == OTFR_ST_RUN)
      else $error("ignore response disabled output");

   delay_runs_on_a: assert property (fault_seen_s(OTFR_RESP_DELAYED) |=>
      out_en_out ##0 (state_ff == OTFR_ST_DLY))
      else $error("delayed response not running on");

   delay_then_off_a: assert property (dly_expired_s |=> !out_en_out)
      else $error("output on after first delay");

   immed_off_a: assert property (fault_seen_s(OTFR_RESP_IMMED) |=> !out_en_out)
      else $error("immediate response left output on");

   hold_off_a: assert property (fault_seen_s(OTFR_RESP_HOLD) |=>
      state_ff == OTFR_ST_HOLD && !out_en_out)
      else $error("hold response left output on");

   hold_release_a: assert property (ce_in && state_ff == OTFR_ST_HOLD && !fault_ff
      |=> out_en_out)
      else $error("output not re-enabled after fault cleared");

   retry_exhaust_a: assert property (ce_in && state_ff == OTFR_ST_OFF && tmr_done
      && fault_ff && retry_ff == OTFR_RETRY_LAST |=> state_ff == OTFR_ST_LATCH)
      else $error("retries not exhausted on last attempt");

   unlimited_a: assert property (state_ff == OTFR_ST_OFF && retry_ff == OTFR_RETRY_UNLIM
      |=> state_ff != OTFR_ST_LATCH)
      else $error("unlimited retries latched off");

   latch_stays_a: assert property (state_ff == OTFR_ST_LATCH |=>
      (state_ff == OTFR_ST_LATCH && !out_en_out) [*2])
      else $error("latched shutdown released without reset");

   dly1_target_a: assert property (fault_seen_s(OTFR_RESP_DELAYED) |->
      tmr_start && tmr_target == otfr_dly1_ms(cfg_ff.delay))
      else $error("first delay not loaded");

endmodule

/* File: dv/otfr_host.sv */
// Host model: reaches the configuration register through the plain register port.
// Assumes its tasks are called from one process; drives at falling edges of clk_sys_in.
module otfr_host
   import otfr_pkg::*;
(
   // Clock
   input wire logic clk_sys_in,
   // Register port toward the device
   output logic [7:0] reg_addr_out,
   output logic reg_wr_out,
   output logic [7:0] reg_wdata_out,
   input wire logic [7:0] reg_rdata_in
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      reg_addr_out = 8'h00;
      reg_wr_out = 1'b0;
      reg_wdata_out = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data is inverted after the strobe so nothing can lean on a stale byte
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_sys_in);
      reg_addr_out = addr;
      reg_wdata_out = data;
      reg_wr_out = 1'b1;
      @(negedge clk_sys_in);
      reg_wr_out = 1'b0;
      reg_wdata_out = ~data;
   endtask

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk_sys_in);
      reg_addr_out = addr;
      @(negedge clk_sys_in);
      data = reg_rdata_in;
   endtask
endmodule

/* File: dv/otfr_top_tb_top.sv */
// Self-checking bench of the fault-response sequencer.
// Assumes a shortened millisecond (MSC cycles) so the longest delays stay short.
module otfr_top_tb_top
   import otfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int MSC = 4;
   logic clk_sys_in, rst_in, ce_in, ot_fault_in, reg_wr_in, out_en_out;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
   logic [4:0] fsm_state_out;
   logic [2:0] retries_left_out;
   int errors = 0;
   int num_checks = 0;
   int d1[8] = '{10, 20, 40, 80, 160, 320, 640, 1280};
   int d2[8] = '{252, 558, 924, 1260, 1596, 1932, 2268, 2604};

   otfr_top #(.MS_CYCLES_P(MSC)) dut_u (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .ce_in(ce_in), .ot_fault_in(ot_fault_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .out_en_out(out_en_out), .fsm_state_out(fsm_state_out),
      .retries_left_out(retries_left_out));

   otfr_host host_u (.clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr_in),
      .reg_wr_out(reg_wr_in), .reg_wdata_out(reg_wdata_in), .reg_rdata_in(reg_rdata_out));

   initial
   begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t ns: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic do_reset(input logic [7:0] cfg);
      @(negedge clk_sys_in);
      rst_in = 1'b1;
      ot_fault_in = 1'b0;
      repeat (10) @(negedge clk_sys_in);
      rst_in = 1'b0;
      host_u.write_reg(OTFR_CFG_ADDR, cfg);
      check(fsm_state_out, OTFR_ST_RUN, "run after reset");
      check(out_en_out, 1'b1, "on after reset");
   endtask

   // Bounded wait; n is the number of falling edges spent
   task automatic wait_st(input logic [4:0] st, input int lim, output int n);
      n = 0;
      while (fsm_state_out !== st && n < lim)
      begin
         @(negedge clk_sys_in);
         n++;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_regs();
      logic [7:0] rd;
      rst_in = 1'b1;
      repeat (10) @(negedge clk_sys_in);
      rst_in = 1'b0;
      host_u.read_reg(OTFR_CFG_ADDR, rd);
      check(rd, 8'h00, "cfg reset");
      check(out_en_out, 1'b1, "out_en reset");
      host_u.write_reg(OTFR_CFG_ADDR, 8'hA5);
      host_u.write_reg(8'h51, 8'h3C);
      host_u.read_reg(OTFR_CFG_ADDR, rd);
      check(rd, 8'hA5, "cfg readback");
      host_u.read_reg(8'h51, rd);
      check(rd, 8'h00, "unmapped read");
      ce_in = 1'b0;
      host_u.write_reg(OTFR_CFG_ADDR, 8'h5A);
      ce_in = 1'b1;
      host_u.read_reg(OTFR_CFG_ADDR, rd);
      check(rd, 8'hA5, "frozen write");
   endtask

   task automatic test_ignore();
      do_reset(8'h3F);
      ot_fault_in = 1'b1;
      repeat (300) @(negedge clk_sys_in);
      check(out_en_out, 1'b1, "ignored fault");
      check(fsm_state_out, OTFR_ST_RUN, "ignore state");
   endtask

   // A fault that clears inside the first delay never turns the output off
   task automatic test_drop();
      do_reset(8'h4B);
      ot_fault_in = 1'b1;
      repeat (100) @(negedge clk_sys_in);
      check(out_en_out, 1'b1, "on during delay");
      check(fsm_state_out, OTFR_ST_DLY, "delay state");
      ot_fault_in = 1'b0;
      repeat (20) @(negedge clk_sys_in);
      check(fsm_state_out, OTFR_ST_RUN, "back to run");
   endtask

   task automatic test_delays();
      int n;
      for (int k = 0; k < 8; k++)
      begin
         do_reset({OTFR_RESP_DELAYED, OTFR_RETRY_LAST, 3'(k)});
         ot_fault_in = 1'b1;
         wait_st(OTFR_ST_OFF, 20000, n);
         check(n >= d1[k] * MSC && n <= d1[k] * MSC + 8, 1'b1, "first delay");
         check(out_en_out, 1'b0, "off after delay");
         wait_st(OTFR_ST_LATCH, 20000, n);
         check(n >= d2[k] * MSC - 4 && n <= d2[k] * MSC + 4, 1'b1, "retry gap");
         ot_fault_in = 1'b0;
         repeat (20) @(negedge clk_sys_in);
         check(out_en_out, 1'b0, "stays latched");
      end
   endtask

   task automatic test_immed();
      do_reset({OTFR_RESP_IMMED, 3'h2, 3'h0});
      ot_fault_in = 1'b1;
      repeat (8) @(negedge clk_sys_in);
      check(out_en_out, 1'b0, "immediate off");
      check(retries_left_out, 3'h2, "retry load");
      repeat (1015) @(negedge clk_sys_in);
      check(retries_left_out, 3'h1, "one attempt used");
      check(fsm_state_out, OTFR_ST_OFF, "still off");
      ot_fault_in = 1'b0;
      repeat (1010) @(negedge clk_sys_in);
      check(out_en_out, 1'b1, "restart on");
      check(fsm_state_out, OTFR_ST_RUN, "restart run");
   endtask

   task automatic test_unlim();
      do_reset({OTFR_RESP_IMMED, OTFR_RETRY_UNLIM, 3'h0});
      ot_fault_in = 1'b1;
      repeat (2030) @(negedge clk_sys_in);
      check(retries_left_out, 3'h7, "unlimited count");
      check(fsm_state_out, OTFR_ST_OFF, "never latches");
   endtask

   task automatic test_hold();
      do_reset({OTFR_RESP_HOLD, OTFR_RETRY_NONE, 3'h0});
      ot_fault_in = 1'b1;
      repeat (1100) @(negedge clk_sys_in);
      check(out_en_out, 1'b0, "hold off");
      check(fsm_state_out, OTFR_ST_HOLD, "hold state");
      ot_fault_in = 1'b0;
      repeat (8) @(negedge clk_sys_in);
      check(out_en_out, 1'b1, "hold reenable");
   endtask

   // Zero retries makes the first shutdown final in both timed responses
   task automatic test_final();
      int n;
      do_reset({OTFR_RESP_IMMED, OTFR_RETRY_NONE, 3'h0});
      ot_fault_in = 1'b1;
      repeat (8) @(negedge clk_sys_in);
      check(fsm_state_out, OTFR_ST_LATCH, "immediate final");
      ot_fault_in = 1'b0;
      repeat (1100) @(negedge clk_sys_in);
      check(out_en_out, 1'b0, "final stays off");
      do_reset({OTFR_RESP_DELAYED, OTFR_RETRY_NONE, 3'h0});
      ot_fault_in = 1'b1;
      wait_st(OTFR_ST_LATCH, 200, n);
      check(n >= d1[0] * MSC && n <= d1[0] * MSC + 8, 1'b1, "delayed final");
      check(out_en_out, 1'b0, "delayed final off");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Limit sits about two fifths above the expected run length
   initial
   begin
      #(90000 * 50);
      errors++;
      give_verdict();
   end

   initial
   begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      ot_fault_in = 1'b0;
      test_regs();
      test_ignore();
      test_drop();
      test_immed();
      test_unlim();
      test_hold();
      test_final();
      test_delays();
      give_verdict();
   end
endmodule
